/* logic/dmrs_mode_reg.v */
// first mode register of the memory: command decode, field decode, burst order
`include "dmrs_map.vh"
module dmrs_mode_reg #(
	parameter AW = 15, // address width
	parameter DLLR_CYCLES = 8 // count loaded for the dll reset; busy lasts one cycle more
) (
	input wire clk, // memory clock
	input wire rst, // async reset, active high
	input wire cs_n, // chip select
	input wire ras_n, // row strobe
	input wire cas_n, // column strobe
	input wire we_n, // write enable
	input wire cke, // clock enable
	input wire [2:0] ba, // bank address
	input wire [AW-1:0] addr, // address bus
	input wire [3:0] added_latency, // added latency from second register
	input wire [3:0] precharge_period, // precharge period in cycles
	input wire col_start, // start a column access burst
	input wire col_write, // access is a write
	input wire [2:0] col_addr, // starting column bits 2:0
	input wire col_bc_n, // burst chop select, low chops
	output reg [AW-1:0] first_mode_register, // stored register contents
	output reg mode_written, // pulse: register was loaded
	output reg dll_reset_pulse, // pulse: dll reset launched
	output reg dll_reset_busy, // dll reset in progress
	output reg interleaved, // burst type
	output reg [1:0] burst_mode, // burst length field
	output reg [3:0] column_read_latency, // decoded latency
	output reg [4:0] total_read_latency, // added plus column latency
	output reg [4:0] auto_precharge_write_delay, // write recovery plus precharge
	output reg [3:0] write_recovery, // decoded write recovery cycles
	output reg test_mode, // test mode flag
	output reg [3:0] write_start_delay, // internal write start offset
	output reg beat_valid, // beat output slot active
	output reg beat_drive, // data drivers enabled
	output reg [2:0] beat_index // column of the current beat
);
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire mrs_cmd;
	reg [7:0] dll_cnt;
	reg [2:0] beat_cnt;
	reg [2:0] beat_start;
	reg beat_chop;
	reg beat_wr;
	reg beat_il;
	reg [2:0] seq_idx;
	reg [2:0] next_index;
	reg [3:0] cl_dec;
	reg [3:0] wr_dec;
	wire [2:0] next_cnt;
	wire chop_now;
	// first register selected with all strobes and bank bits low, clock enabled;
	// with clock enable low the command pins are not registered at all, and the
	// other bank codes belong to registers this block does not hold
	assign mrs_cmd = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n & (ba == `DMRS_BA_MR0);
	// beat counter one step ahead, so each column lands in the slot it belongs to
	assign next_cnt = beat_cnt + 3'h1;
	// chop decided by the field, or on the fly by bit 12 of the access
	// the select pin is only looked at in on-the-fly mode; fixed modes ignore it
	assign chop_now = (burst_mode == `DMRS_BL_FIX4) |
		((burst_mode == `DMRS_BL_OTF) & ~col_bc_n);
	// ----------------------------------------
	// register store and dll reset
	// ----------------------------------------
	// loads only on a decoded command; dll bit is self clearing
	// a new command while the dll count runs wins over the count: its own bit 8
	// either restarts the count or leaves the bit low
	// only the register changes here; the memory array is never touched
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			first_mode_register <= `DMRS_REG_RST;
			mode_written <= 1'b0;
			dll_reset_pulse <= 1'b0;
			dll_reset_busy <= 1'b0;
			dll_cnt <= 8'h00;
		end else begin
			mode_written <= mrs_cmd;
			dll_reset_pulse <= mrs_cmd & addr[`DMRS_DLLR_BIT];
			if (mrs_cmd) begin
				first_mode_register <= addr;
				first_mode_register[`DMRS_DLLR_BIT] <= addr[`DMRS_DLLR_BIT];
				if (addr[`DMRS_DLLR_BIT]) begin
					dll_reset_busy <= 1'b1;
					dll_cnt <= DLLR_CYCLES[7:0];
				end
			end else if (dll_reset_busy) begin
				// count spent: the reset is carried out, so the request bit drops
				if (dll_cnt == 8'h00) begin
					dll_reset_busy <= 1'b0;
					first_mode_register[`DMRS_DLLR_BIT] <= 1'b0;
				end else begin
					dll_cnt <= dll_cnt - 8'h01;
				end
			end
		end
	end
	// ----------------------------------------
	// field decode
	// ----------------------------------------
	// latency code in bits 6:4 with bit 2 as extension; the sum wraps in four bits,
	// so a code above the supported range reads back as a small latency
	always @* begin
		cl_dec = `DMRS_CL_BASE + {1'b0, first_mode_register[`DMRS_CL_MSB:`DMRS_CL_LSB]};
		if (first_mode_register[`DMRS_CL_B0])
			cl_dec = cl_dec + 4'h8;
	end
	// write recovery bits 11:9 as clock cycles; the reserved code reads as zero,
	// which the controller must never program
	always @* begin
		case (first_mode_register[`DMRS_WR_MSB:`DMRS_WR_LSB])
			3'h0: wr_dec = 4'h0; // reserved code reads as zero
			3'h1: wr_dec = 4'h5;
			3'h2: wr_dec = 4'h6;
			3'h3: wr_dec = 4'h7;
			3'h4: wr_dec = 4'h8;
			3'h5: wr_dec = 4'ha;
			3'h6: wr_dec = 4'hc;
			default: wr_dec = 4'he;
		endcase
	end
	// decoded fields registered for the datapath
	// they follow the register one cycle later,
	// so they stand one cycle after the command edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			interleaved <= 1'b0;
			burst_mode <= `DMRS_BL_FIX8;
			column_read_latency <= `DMRS_CL_BASE;
			total_read_latency <= 5'h00;
			auto_precharge_write_delay <= 5'h00;
			write_recovery <= 4'h0;
			test_mode <= 1'b0;
			write_start_delay <= 4'h0;
		end else begin
			interleaved <= first_mode_register[`DMRS_BT_BIT];
			burst_mode <= first_mode_register[`DMRS_BL_MSB:`DMRS_BL_LSB];
			column_read_latency <= cl_dec;
			total_read_latency <= {1'b0, added_latency} + {1'b0, cl_dec};
			write_recovery <= wr_dec;
			auto_precharge_write_delay <= {1'b0, wr_dec} + {1'b0, precharge_period};
			test_mode <= first_mode_register[`DMRS_TM_BIT];
			// fixed chop pulls the internal write in; on the fly does not
			// the offset is relative: zero for fixed chop, two clocks otherwise
			write_start_delay <= (first_mode_register[`DMRS_BL_MSB:`DMRS_BL_LSB] ==
				`DMRS_BL_FIX4) ? 4'h0 : `DMRS_WR_EARLY;
		end
	end
	// ----------------------------------------
	// burst order generator
	// ----------------------------------------
	// sequential wraps within the half, interleaved is start xor beat;
	// the column is worked out for the beat that follows the current one
	always @* begin
		seq_idx = {beat_start[2] ^ next_cnt[2], beat_start[1:0] + next_cnt[1:0]};
		if (beat_wr)
			next_index = {beat_start[2] ^ next_cnt[2], next_cnt[1:0]};
		else if (beat_il)
			next_index = beat_start ^ next_cnt;
		else
			next_index = seq_idx;
	end
	// eight beat slots per access; chopped reads float the last four
	// a start while a burst runs is ignored; the controller waits for the end
	// writes never drive, but their slot count still runs to eight
	// beat_drive stands low outside bursts so the data pins float at rest
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			beat_valid <= 1'b0;
			beat_drive <= 1'b0;
			beat_index <= 3'h0;
			beat_cnt <= 3'h0;
			beat_start <= 3'h0;
			beat_chop <= 1'b0;
			beat_wr <= 1'b0;
			beat_il <= 1'b0;
		end else if (col_start && !beat_valid) begin
			beat_valid <= 1'b1;
			beat_cnt <= 3'h0;
			beat_chop <= chop_now;
			beat_wr <= col_write;
			beat_il <= interleaved;
			// writes ignore column bits 1:0
			beat_start <= col_write ? {col_addr[2], 2'h0} : col_addr;
			beat_drive <= ~col_write;
			beat_index <= col_write ? {col_addr[2], 2'h0} : col_addr;
		end else if (beat_valid) begin
			beat_cnt <= beat_cnt + 3'h1;
			beat_index <= next_index;
			if (beat_cnt == `DMRS_BEAT_LAST) begin
				beat_valid <= 1'b0;
				beat_drive <= 1'b0;
			end else if (beat_chop && !beat_wr && beat_cnt == `DMRS_BEAT_HALF - 3'h1) begin
				beat_drive <= 1'b0;
			end
		end
	end
endmodule

/* pkg/dmrs_map.vh */
// constants for the first mode register decode block
`ifndef DMRS_MAP_VH
`define DMRS_MAP_VH
// ----------------------------------------
// mode register field positions
// ----------------------------------------
`define DMRS_BL_LSB 0
`define DMRS_BL_MSB 1
`define DMRS_CL_B0 2
`define DMRS_BT_BIT 3
`define DMRS_CL_LSB 4
`define DMRS_CL_MSB 6
`define DMRS_TM_BIT 7
`define DMRS_DLLR_BIT 8
`define DMRS_WR_LSB 9
`define DMRS_WR_MSB 11
`define DMRS_PPD_BIT 12
`define DMRS_BC_BIT 12
// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define DMRS_BL_FIX8 2'h0
`define DMRS_BL_OTF 2'h1
`define DMRS_BL_FIX4 2'h2
`define DMRS_BA_MR0 3'h0
`define DMRS_REG_RST 15'h0000
`define DMRS_CL_BASE 4'h4
`define DMRS_WR_EARLY 4'h2
`define DMRS_DLLR_CYC 8'h0f
`define DMRS_BEAT_HALF 3'h4
`define DMRS_BEAT_LAST 3'h7
`endif

/* verif/dmrs_ctl_model.sv */
// controller model issuing mode set and column commands
module dmrs_ctl_model #(parameter MOD = 12, parameter LOCK = 16) (
	input wire logic clk, // memory clock
	output logic cs_n, ras_n, cas_n, we_n, // command strobes
	output logic [2:0] ba, col_addr, // bank address, start column
	output logic [14:0] addr, // address bus
	output logic col_start, col_write, col_bc_n // column access
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cs_n, ras_n, cas_n, we_n, ba, addr} = 22'h3c_0000;
		{col_start, col_write, col_bc_n, col_addr} = 6'h08;
	end
	// full register value each time, reserved and test bits forced low
	task mode_set(input logic [2:0] b, input logic [14:0] v);
		@(posedge clk) #1;
		{cs_n, ras_n, cas_n, we_n} = 4'h0;
		ba = b & 3'h3;
		addr = v & 15'h1f7f;
		@(posedge clk) #1;
		cs_n = 1'b1;
		addr = ~addr; // deselected, bus no longer holds the value
		repeat (v[8] ? LOCK : MOD) @(posedge clk);
		#1;
	endtask
	// issued only while idle: caller lets the last burst finish first
	task burst(input logic w, input logic [2:0] c, input logic bcn);
		@(posedge clk) #1;
		{col_start, col_write, col_addr, col_bc_n} = {1'b1, w, c, bcn};
		@(posedge clk) #1;
		col_start = 1'b0;
		col_addr = ~c;
	endtask
endmodule

/* verif/dmrs_props.sv */
// assertion checker for the first mode register block
module dmrs_props #(parameter AW = 15) (
	input wire logic clk, rst, cke, cs_n, ras_n, cas_n, we_n, // clock, reset, command
	input wire logic [2:0] ba, // bank address
	input wire logic [AW-1:0] addr, first_mode_register, // address, stored value
	input wire logic mode_written, dll_reset_busy, interleaved, col_start, beat_valid, // status
	input wire logic [3:0] column_read_latency, added_latency, write_start_delay, // latencies
	input wire logic [4:0] total_read_latency // added plus column
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire take = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n & (ba == 3'h0);
	sequence s_dll; dll_reset_busy [*8] ##1 dll_reset_busy ##1 !dll_reset_busy; endsequence
	sequence s_beats; beat_valid [*8] ##1 !beat_valid; endsequence
	property p_take; take |=> mode_written && first_mode_register == $past(addr); endproperty
	a_take: assert property (p_take) else $error("load wrong");
	property p_hold; !mode_written |-> $stable({first_mode_register[14:9], first_mode_register[7:0]}); endproperty
	a_hold: assert property (p_hold) else $error("register moved");
	property p_dll; $rose(dll_reset_busy) |-> s_dll ##0 !first_mode_register[8]; endproperty
	a_dll: assert property (p_dll) else $error("dll count wrong");
	property p_bt; mode_written |=> interleaved == $past(first_mode_register[3]); endproperty
	a_bt: assert property (p_bt) else $error("burst type wrong");
	property p_cl; mode_written |=> column_read_latency == 4'h4 + $past(first_mode_register[6:4])
		+ ($past(first_mode_register[2]) ? 4'h8 : 4'h0); endproperty
	a_cl: assert property (p_cl) else $error("latency wrong");
	property p_rl; mode_written |=> ##1 total_read_latency == column_read_latency + added_latency; endproperty
	a_rl: assert property (p_rl) else $error("total latency wrong");
	property p_ws; mode_written |=> write_start_delay == (($past(first_mode_register[1:0]) == 2'h2) ? 4'h0 : 4'h2); endproperty
	a_ws: assert property (p_ws) else $error("write start wrong");
	property p_beat; col_start && !beat_valid |=> s_beats; endproperty
	a_beat: assert property (p_beat) else $error("burst length wrong");
endmodule
bind dmrs_mode_reg dmrs_props #(.AW(AW)) u_props (.*);

/* verif/testbench.sv */
// self-checking bench for the first mode register block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, cke = 1'b0;
	logic [3:0] added_latency = 4'h3, precharge_period = 4'h6;
	logic [3:0] wr_tab [0:7] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he};
	wire cs_n, ras_n, cas_n, we_n, col_start, col_write, col_bc_n, mode_written, dll_reset_pulse;
	wire dll_reset_busy, interleaved, test_mode, beat_valid, beat_drive;
	wire [2:0] ba, col_addr, beat_index;
	wire [14:0] addr, first_mode_register;
	wire [1:0] burst_mode;
	wire [3:0] column_read_latency, write_recovery, write_start_delay;
	wire [4:0] total_read_latency, auto_precharge_write_delay;
	int n_fail = 0, checks = 0, n_dll = 0;
	logic exp_il = 1'b0; // burst type the last t_mode call asked for
	always #4 clk = ~clk;
	always @(posedge clk) if (dll_reset_pulse === 1'b1) n_dll <= n_dll + 1;
	dmrs_ctl_model ctl (
		.clk(clk),
		.cs_n(cs_n),
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.ba(ba),
		.col_addr(col_addr),
		.addr(addr),
		.col_start(col_start),
		.col_write(col_write),
		.col_bc_n(col_bc_n)
	);
	dmrs_mode_reg uut (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.cke(cke),
		.ba(ba),
		.addr(addr),
		.added_latency(added_latency),
		.precharge_period(precharge_period),
		.col_start(col_start),
		.col_write(col_write),
		.col_addr(col_addr),
		.col_bc_n(col_bc_n),
		.first_mode_register(first_mode_register),
		.mode_written(mode_written),
		.dll_reset_pulse(dll_reset_pulse),
		.dll_reset_busy(dll_reset_busy),
		.interleaved(interleaved),
		.burst_mode(burst_mode),
		.column_read_latency(column_read_latency),
		.total_read_latency(total_read_latency),
		.auto_precharge_write_delay(auto_precharge_write_delay),
		.write_recovery(write_recovery),
		.test_mode(test_mode),
		.write_start_delay(write_start_delay),
		.beat_valid(beat_valid),
		.beat_drive(beat_drive),
		.beat_index(beat_index)
	);
	task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// write a value and check every decoded field
	task t_mode(input logic [14:0] v);
		logic [15:0] cl;
		cl = 4 + v[6:4] + {v[2], 3'h0};
		exp_il = v[3];
		ctl.mode_set(3'h0, v);
		cmp("register", v, first_mode_register);
		cmp("type", v[3], interleaved);
		cmp("length", v[1:0], burst_mode);
		cmp("latency", cl, column_read_latency);
		cmp("total", cl + added_latency, total_read_latency);
		cmp("recovery", wr_tab[v[11:9]], write_recovery);
		cmp("ap delay", wr_tab[v[11:9]] + precharge_period, auto_precharge_write_delay);
		cmp("start", (v[1:0] == 2'h2) ? 0 : 2, write_start_delay);
		cmp("test mode", v[7], test_mode);
	endtask
	// other bank and low clock enable must leave the register alone
	task t_refuse;
		ctl.mode_set(3'h1, 15'h0003);
		cke = 1'b0;
		ctl.mode_set(3'h0, 15'h0005);
		cke = 1'b1;
		cmp("refused", 15'h0e3d, first_mode_register);
	endtask
	task t_dll;
		ctl.mode_set(3'h0, 15'h0104);
		cmp("dll pulses", 1, n_dll[15:0]);
		cmp("dll clear", 15'h0004, first_mode_register);
		cmp("dll busy", 0, dll_reset_busy);
	endtask
	// one burst: beat columns and driver enables slot by slot
	task t_burst(input logic w, input logic [2:0] s, input logic bcn, input logic ch);
		logic [2:0] e;
		ctl.burst(w, s, bcn);
		for (int i = 0; i < 8; i++) begin
			e = exp_il ? s ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
			if (w) e = {s[2], i[1:0]};
			if (!(ch && i > 3)) cmp("beat", e, beat_index);
			cmp("drive", !w && !(ch && i > 3), beat_drive);
			@(posedge clk) #1;
		end
		cmp("burst end", 0, beat_valid);
	endtask
	task t_orders;
		for (int t = 0; t < 2; t++) begin
			t_mode({t[0], 3'h0});
			for (int s = 0; s < 8; s++) t_burst(1'b0, s[2:0], 1'b0, 1'b0);
		end
		t_mode(15'h0001);
		t_burst(1'b0, 3'h3, 1'b0, 1'b1);
		t_burst(1'b1, 3'h5, 1'b0, 1'b1);
		t_mode(15'h0222);
		t_burst(1'b0, 3'h7, 1'b1, 1'b1);
		t_burst(1'b1, 3'h6, 1'b1, 1'b1);
		t_mode(15'h0009);
		t_burst(1'b0, 3'h5, 1'b0, 1'b1);
		t_burst(1'b0, 3'h2, 1'b1, 1'b0);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		cmp("reset register", 0, first_mode_register);
		cmp("reset latency", 4, column_read_latency);
		cke = 1'b1;
		t_mode(15'h0e3d);
		t_refuse;
		t_dll;
		t_orders;
		end_sim;
	end
endmodule
